// ==== design/tucsc_pkg.sv ====
package tucsc_pkg;
  // Register word addresses (Avalon word index)
  localparam logic [1:0] ADDR_PER_EN   = 2'h0;
  localparam logic [1:0] ADDR_PRESCALE = 2'h1;
  localparam logic [1:0] ADDR_STOP     = 2'h2;
  localparam logic [1:0] ADDR_CLKSEL   = 2'h3;
  localparam int ADDR_W = 2;
  // Field positions
  localparam int CLK_EN_BIT      = 0;
  localparam int PRS_A_LSB       = 0;
  localparam int PRS_W           = 4;
  localparam int PRS_B_LSB       = 4;
  localparam int STOP_CH_LSB     = 0;
  localparam int NUM_CH          = 8;
  localparam int STOP_HI1_BIT    = 9;
  localparam int STOP_HI3_BIT    = 11;
  localparam int SEL_W           = 2;
  localparam int DIV_W           = 15;
  // Reset values
  localparam logic [7:0]  PER_EN_RST   = 8'h00;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  localparam logic [15:0] CLKSEL_RST   = 16'h0000;
  // Operation clock select codes
  localparam logic [1:0] SEL_CLK_A = 2'h0;
  localparam logic [1:0] SEL_CLK_B = 2'h2;
endpackage

// ==== design/tucsc_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucsc_prescaler #(
  parameter int DIV_W = 15
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] code_a_i,
  input  wire logic [3:0] code_b_i,
  output logic            tick_a_o,
  output logic            tick_b_o
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W:0]   carry;

  // Free counter, cleared while unit clock is gated
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      cnt_q <= '0;
    end
  end

  // Tick when low bits all ones: period 2**code
  always_comb begin
    carry[0] = 1'b1;
    for (int i = 0; i < DIV_W; i++) begin
      carry[i+1] = carry[i] & cnt_q[i];
    end
  end

  assign tick_a_o = ce_i & carry[code_a_i];
  assign tick_b_o = ce_i & carry[code_b_i];
endmodule // tucsc_prescaler
`default_nettype wire

// ==== design/tucsc_stop_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucsc_stop_gen #(
  parameter int NUM_CH = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              clk_en_i,
  input  wire logic              wr_i,
  input  wire logic [15:0]       wdata_i,
  output logic      [NUM_CH-1:0] stop_o,
  output logic      [1:0]        stop_hi_o
);
  // One-cycle pulses, never stored as register state
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_o    <= '0;
      stop_hi_o <= '0;
    end else if (clk_en_i) begin
      stop_o <= wr_i ? wdata_i[tucsc_pkg::STOP_CH_LSB +: NUM_CH]
                     : '0;
      stop_hi_o <= wr_i ? {wdata_i[tucsc_pkg::STOP_HI3_BIT],
                           wdata_i[tucsc_pkg::STOP_HI1_BIT]}
                        : 2'h0;
    end
  end
endmodule // tucsc_stop_gen
`default_nettype wire

// ==== design/tucsc_top.sv ====
// Overview of operation
// - Enable bit 0 gates timer unit clock
// - Clock A equals system clock over 2**code
// - Writing one to bit n stops channel
// - Bits 11 and 9 stop upper halves
// - Select 00 picks clock A, 10 B
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tucsc_top #(
  parameter int NUM_CH = tucsc_pkg::NUM_CH
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  input  wire logic [1:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [1:0]          avs_response,
  output logic                     timer_unit_clock_enable_o,
  output logic                     operation_clock_a_o,
  output logic                     operation_clock_b_o,
  output logic      [NUM_CH-1:0]   channel_tick_o,
  output logic      [NUM_CH-1:0]   channel_stop_o,
  output logic      [1:0]          upper_half_stop_o
);
  logic [7:0]  per_en_q;
  logic [15:0] prescale_q;
  logic [15:0] clksel_q;
  logic        ack_q;
  logic        wr_go;
  logic        rd_go;
  logic        unit_en;
  logic [1:0]  sel;

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = old_v;
    if (be[0]) merge16[7:0]  = wd[7:0];
    if (be[1]) merge16[15:8] = wd[15:8];
  endfunction

  // One wait cycle then acknowledge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign rd_go = avs_read & ack_q;
  assign avs_response = 2'h0;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Peripheral enable register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      per_en_q <= tucsc_pkg::PER_EN_RST;
    end else if (ce_i && wr_go && avs_byteenable[0] &&
                 avs_address == tucsc_pkg::ADDR_PER_EN) begin
      per_en_q <= avs_writedata[7:0];
    end
  end

  // Prescaler select register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prescale_q <= tucsc_pkg::PRESCALE_RST;
    end else if (ce_i && wr_go &&
                 avs_address == tucsc_pkg::ADDR_PRESCALE) begin
      prescale_q <= merge16(prescale_q, avs_writedata, avs_byteenable);
    end
  end

  // Clock select: two bits per channel
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clksel_q <= tucsc_pkg::CLKSEL_RST;
    end else if (ce_i && wr_go &&
                 avs_address == tucsc_pkg::ADDR_CLKSEL) begin
      clksel_q <= merge16(clksel_q, avs_writedata, avs_byteenable);
    end
  end

  // Read data registered in the wait cycle, before acknowledge
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce_i && (avs_read & ~ack_q)) begin
      case (avs_address)
        tucsc_pkg::ADDR_PER_EN:   avs_readdata <= {24'h000000, per_en_q};
        tucsc_pkg::ADDR_PRESCALE: avs_readdata <= {16'h0000, prescale_q};
        tucsc_pkg::ADDR_CLKSEL:   avs_readdata <= {16'h0000, clksel_q};
        default:                  avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign unit_en = ce_i & per_en_q[tucsc_pkg::CLK_EN_BIT];
  assign timer_unit_clock_enable_o = per_en_q[tucsc_pkg::CLK_EN_BIT];

  tucsc_prescaler #(
    .DIV_W (tucsc_pkg::DIV_W)
  ) u_prescaler (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (unit_en),
    .code_a_i   (prescale_q[tucsc_pkg::PRS_A_LSB +: tucsc_pkg::PRS_W]),
    .code_b_i   (prescale_q[tucsc_pkg::PRS_B_LSB +: tucsc_pkg::PRS_W]),
    .tick_a_o   (operation_clock_a_o),
    .tick_b_o   (operation_clock_b_o)
  );

  // Per-channel operation clock selection
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sel
      if (g * tucsc_pkg::SEL_W < 16) begin : g_have
        assign channel_tick_o[g] =
          (clksel_q[g*tucsc_pkg::SEL_W +: tucsc_pkg::SEL_W]
             == tucsc_pkg::SEL_CLK_B) ? operation_clock_b_o
                                      : operation_clock_a_o;
      end else begin : g_none
        assign channel_tick_o[g] = operation_clock_a_o;
      end
    end
  endgenerate

  tucsc_stop_gen #(
    .NUM_CH (NUM_CH)
  ) u_stop (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .clk_en_i   (ce_i),
    .wr_i       (wr_go && avs_address == tucsc_pkg::ADDR_STOP),
    .wdata_i    (avs_writedata[15:0]),
    .stop_o     (channel_stop_o),
    .stop_hi_o  (upper_half_stop_o)
  );

  assign sel = clksel_q[1:0];

  // Prescaler period check helper
  logic [15:0] gap_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= 16'h0000;
    end else if (unit_en) begin
      gap_q <= operation_clock_a_o ? 16'h0000 : gap_q + 16'h0001;
    end
  end

  clk_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !per_en_q[0] |-> !operation_clock_a_o && !operation_clock_b_o)
    else $error("operation clock ticks while gated");
  div_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    unit_en && prescale_q[3:0] == 4'h0 |-> operation_clock_a_o)
    else $error("undivided clock missing tick");
  div_period_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    unit_en && $stable(prescale_q) && operation_clock_a_o && $past(unit_en)
    && $past(operation_clock_a_o) |-> prescale_q[3:0] == 4'h0)
    else $error("clock a ticks back to back when divided");
  stop_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && wr_go && avs_address == tucsc_pkg::ADDR_STOP
    |=> channel_stop_o == $past(avs_writedata[7:0]))
    else $error("stop pulse does not follow write");
  stop_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && !(wr_go && avs_address == tucsc_pkg::ADDR_STOP)
    |=> channel_stop_o == 8'h00 && upper_half_stop_o == 2'h0)
    else $error("stop pulse lasts more than a cycle");
  upper_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && wr_go && avs_address == tucsc_pkg::ADDR_STOP
    |=> upper_half_stop_o == {$past(avs_writedata[11]),
                              $past(avs_writedata[9])})
    else $error("upper half stop mismatch");
  sel_route_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sel == tucsc_pkg::SEL_CLK_B |-> channel_tick_o[0] == operation_clock_b_o
    )
    else $error("channel 0 clock select wrong");
  stop_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && avs_read && !ack_q && avs_address == tucsc_pkg::ADDR_STOP
    |=> avs_readdata == 32'h0000_0000)
    else $error("stop register reads nonzero");
  bus_ack_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ce_i && (avs_read || avs_write) && !ack_q |=> !avs_waitrequest)
    else $error("bus answer late");

  stop_all_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    channel_stop_o == 8'hFF);
  upper_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    upper_half_stop_o == 2'h3);
  slow_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    gap_q == 16'h0007 && prescale_q[3:0] == 4'h3);
  clk_b_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sel == tucsc_pkg::SEL_CLK_B && operation_clock_b_o);
endmodule // tucsc_top
`default_nettype wire

// ==== bench/tb_timer_unit_clock_and_stop_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_timer_unit_clock_and_stop_control;
  localparam int LIMIT = 90000;
  logic        core_clk_i     = 1'b0;
  logic        rst_b_i        = 1'b0;
  logic        ce_i           = 1'b1;
  logic [1:0]  avs_address    = 2'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        timer_unit_clock_enable_o;
  logic        operation_clock_a_o;
  logic        operation_clock_b_o;
  logic [7:0]  channel_tick_o;
  logic [7:0]  channel_stop_o;
  logic [1:0]  upper_half_stop_o;
  int          fail_count     = 0;
  int          tests_run      = 0;
  int          cyc            = 0;
  int          per;
  logic [31:0] rd;
  logic [15:0] d;
  logic [7:0]  ex;
  logic [3:0]  cb;

  always #12.5 core_clk_i = ~core_clk_i;

  tucsc_top u_tucsc_top (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .timer_unit_clock_enable_o(timer_unit_clock_enable_o),
    .operation_clock_a_o(operation_clock_a_o),
    .operation_clock_b_o(operation_clock_b_o),
    .channel_tick_o(channel_tick_o), .channel_stop_o(channel_stop_o),
    .upper_half_stop_o(upper_half_stop_o)
  );

  task automatic results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [31:0] wd, input logic [3:0] be);
    @(posedge core_clk_i);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= ~w;
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  function automatic logic tk(input logic b);
    return b ? operation_clock_b_o : operation_clock_a_o;
  endfunction

  // Cycles between two ticks of one operation clock
  task automatic period(input logic b, output int n);
    n = 0;
    do @(negedge core_clk_i); while (tk(b) !== 1'b1);
    do begin
      @(negedge core_clk_i);
      n++;
    end while (tk(b) !== 1'b1);
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      results();
    end
  end

  initial begin
    void'($urandom(90));
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, 2'(a), 32'h0, 4'hF);
      chk(rd, 32'h0);
    end
    // Clock gate on, then prescaler codes with measured periods
    bus(1'b1, tucsc_pkg::ADDR_PER_EN, 32'h1, 4'h1);
    @(negedge core_clk_i);
    chk(32'(timer_unit_clock_enable_o), 32'h1);
    for (int c = 0; c < 14; c++) begin
      cb = 4'($urandom_range(7));
      bus(1'b1, tucsc_pkg::ADDR_PRESCALE, 32'({cb, 4'(c)}), 4'h3);
      period(1'b0, per);
      chk(32'(per), 32'(1) << c);
      period(1'b1, per);
      chk(32'(per), 32'(1) << cb);
    end
    bus(1'b0, tucsc_pkg::ADDR_PRESCALE, 32'h0, 4'hF);
    chk({24'h0, rd[7:0]}, {24'h0, cb, 4'hD});
    // Gate off: no ticks even at the fastest code
    bus(1'b1, tucsc_pkg::ADDR_PRESCALE, 32'h30, 4'h3);
    bus(1'b1, tucsc_pkg::ADDR_PER_EN, 32'h0, 4'h1);
    @(negedge core_clk_i);
    chk(32'(timer_unit_clock_enable_o), 32'h0);
    repeat (20) begin
      @(negedge core_clk_i);
      chk(32'({operation_clock_a_o, channel_tick_o}), 32'h0);
    end
    bus(1'b1, tucsc_pkg::ADDR_PER_EN, 32'h1, 4'h1);
    // Clock enable low: no ticks at the fastest code
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    repeat (4) begin
      @(negedge core_clk_i);
      chk(32'(operation_clock_a_o), 32'h0);
    end
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    // Per-channel clock select
    for (int j = 0; j < 4; j++) begin
      d = (j == 0) ? 16'hAAAA : (j == 1) ? 16'h0000 : 16'($urandom);
      bus(1'b1, tucsc_pkg::ADDR_CLKSEL, 32'(d), 4'h3);
      repeat (12) begin
        @(negedge core_clk_i);
        for (int k = 0; k < 8; k++) begin
          ex[k] = (d[2*k+:2] == 2'b10) ? operation_clock_b_o
                                       : operation_clock_a_o;
        end
        chk(32'(channel_tick_o), 32'(ex));
      end
    end
    // Stop triggers: pulse once, nothing stored
    for (int j = 0; j < 10; j++) begin
      d = (j == 0) ? 16'hFFFF : (j == 1) ? 16'h0A00 : 16'($urandom);
      bus(1'b1, tucsc_pkg::ADDR_STOP, 32'(d), (j == 2) ? 4'h0 : 4'h3);
      @(negedge core_clk_i);
      chk(32'({upper_half_stop_o, channel_stop_o}),
          32'({d[11], d[9], d[7:0]}));
      @(negedge core_clk_i);
      chk(32'({upper_half_stop_o, channel_stop_o}), 32'h0);
      bus(1'b0, tucsc_pkg::ADDR_STOP, 32'h0, 4'hF);
      chk(rd, 32'h0);
    end
    results();
  end
endmodule // tb_timer_unit_clock_and_stop_control
`default_nettype wire
